// >>> design/strip_input_capture_mask.v
// Hit capture, input test forcing and channel mask toward the pipeline.
// Assumes hit pins async to sys_clk; Wishbone master on sys_clk.
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "capture_defs.vh"
module strip_input_capture_mask #(
    parameter CHANS = `CHAN_COUNT
) (
    input  wire             sys_clk,
    input  wire             rst_b,
    input  wire [CHANS-1:0] hit_in,
    input  wire             cfg_s_in,
    input  wire             cfg_load,
    output wire [1:0]       cal_mode,
    output wire [CHANS-1:0] pipe_data,
    output wire             pipe_valid,
    input  wire             pipe_ready,
    output wire             capture_stall,
    input  wire             wb_cyc_i,
    input  wire             wb_stb_i,
    input  wire             wb_we_i,
    input  wire [3:0]       wb_adr_i,
    input  wire [3:0]       wb_sel_i,
    input  wire [31:0]      wb_dat_i,
    output reg  [31:0]      wb_dat_o,
    output reg              wb_ack_o,
    output reg              wb_err_o
);
    reg  [1:0]       rst_sync_q;
    wire             rst_n;
    reg  [CHANS-1:0] hit_s1_q;
    reg  [CHANS-1:0] hit_s2_q;
    reg  [1:0]       cfg_s1_q;
    reg  [1:0]       cfg_s2_q;
    reg  [31:0]      ctrl_q;
    reg  [CHANS-1:0] mask_q;
    reg  [CHANS-1:0] capture_q;
    reg              cap_valid_q;
    reg  [15:0]      commit_cnt_q;
    wire [CHANS-1:0] shadow;
    wire             commit;
    wire             test_en;
    wire [1:0]       group_sel;
    wire             mask_mode;
    wire             force_lvl;
    wire [CHANS-1:0] forced;
    wire [CHANS-1:0] word_d;
    wire [CHANS-1:0] gated;
    wire             in_ready;
    wire             wb_req;
    wire             wb_hit_mask;
    wire [1:0]       wb_mask_idx;
    integer          i;

    // Byte-lane merge for register writes
    function [31:0] merge_bytes;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  sel;
        integer      b;
        begin
            merge_bytes = old_v;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    merge_bytes[8*b +: 8] = new_v[8*b +: 8];
                end
            end
        end
    endfunction

    // Release reset through two flops
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Pins are async; two flops before any logic looks at them
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hit_s1_q <= {CHANS{1'b0}};
            hit_s2_q <= {CHANS{1'b0}};
            cfg_s1_q <= 2'b00;
            cfg_s2_q <= 2'b00;
        end else begin
            hit_s1_q <= hit_in;
            hit_s2_q <= hit_s1_q;
            cfg_s1_q <= {cfg_load, cfg_s_in};
            cfg_s2_q <= cfg_s1_q;
        end
    end

    assign test_en   = ctrl_q[`CTRL_TEST_EN_BIT];
    assign group_sel = ctrl_q[`CTRL_GROUP_LSB +: 2];
    assign mask_mode = ctrl_q[`CTRL_MASK_MODE];
    assign force_lvl = ctrl_q[`CTRL_FORCE_LVL];
    assign cal_mode  = group_sel;

    // Quarter of the channels forced so pads test without probing all
    genvar g;
    generate
        for (g = 0; g < CHANS; g = g + 1) begin : g_force
            assign forced[g] = (test_en && (g % `GROUP_STRIDE) == group_sel) ?
                               force_lvl : hit_s2_q[g];
        end
    endgenerate

    // Mask bit 0 zeroes its channel in normal mode
    assign gated  = forced & mask_q;
    // Mode 0 gates live hits, mode 1 sends the mask itself
    assign word_d = (mask_mode == `MODE_TEST) ? mask_q : gated;

    mask_shifter #(
        .WIDTH (CHANS)
    ) u_shift (
        .clk      (sys_clk),
        .rst_n    (rst_n),
        .s_in     (cfg_s2_q[0]),
        .load     (cfg_s2_q[1]),
        .shadow_q (shadow),
        .commit   (commit)
    );

    // Input register: one clean clock-wide sample in each cycle that is not stalled
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_q   <= {CHANS{1'b0}};
            cap_valid_q <= 1'b0;
        end else if (in_ready || !cap_valid_q) begin
            capture_q   <= word_d;
            cap_valid_q <= 1'b1;
        end
    end

    // Stalled words are held; a sample taken during a stall is dropped
    assign capture_stall = cap_valid_q & ~in_ready;

    skid_buffer #(
        .WIDTH (CHANS)
    ) u_buf (
        .clk       (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (cap_valid_q),
        .in_ready  (in_ready),
        .in_data   (capture_q),
        .out_valid (pipe_valid),
        .out_ready (pipe_ready),
        .out_data  (pipe_data)
    );

    // Wishbone slave, single-cycle ack after request
    assign wb_req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign wb_hit_mask = (wb_adr_i >= `ADDR_MASK_BASE) &&
                         (wb_adr_i < `ADDR_MASK_BASE + `MASK_WORDS);
    assign wb_mask_idx = wb_adr_i[1:0];

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q       <= `CTRL_RESET;
            mask_q       <= {CHANS{1'b1}};
            commit_cnt_q <= 16'h0000;
            wb_ack_o     <= 1'b0;
            wb_err_o     <= 1'b0;
            wb_dat_o     <= 32'h0000_0000;
        end else begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            if (commit) begin
                mask_q       <= shadow;
                commit_cnt_q <= commit_cnt_q + 16'h0001;
            end
            if (wb_req) begin
                if (wb_adr_i == `ADDR_CTRL) begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {27'h0, ctrl_q[4:0]};
                    if (wb_we_i) begin
                        ctrl_q <= merge_bytes(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_001F;
                    end
                end else if (wb_adr_i == `ADDR_STATUS) begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {14'h0, in_ready, pipe_valid, commit_cnt_q};
                end else if (wb_hit_mask) begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= mask_q[32*wb_mask_idx +: 32];
                    if (wb_we_i && !commit) begin
                        for (i = 0; i < 4; i = i + 1) begin
                            if (wb_mask_idx == i[1:0]) begin
                                mask_q[32*i +: 32] <= merge_bytes(mask_q[32*i +: 32],
                                                      wb_dat_i, wb_sel_i);
                            end
                        end
                    end
                end else begin
                    wb_err_o <= 1'b1;
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end
endmodule // strip_input_capture_mask

// >>> shared/capture_defs.vh
// Constants for the strip hit capture and mask block.
// Assumes inclusion by bare name from design files.
`ifndef CAPTURE_DEFS_VH
`define CAPTURE_DEFS_VH
`define CHAN_COUNT        128
`define GROUP_STRIDE      4
`define ADDR_CTRL         4'h0
`define ADDR_STATUS       4'h1
`define ADDR_MASK_BASE    4'h4
`define MASK_WORDS        4
`define CTRL_TEST_EN_BIT  0
`define CTRL_GROUP_LSB    1
`define CTRL_MASK_MODE    3
`define CTRL_FORCE_LVL    4
`define CTRL_RESET        32'h0000_0000
`define MASK_RESET        32'hFFFF_FFFF
`define MODE_NORMAL       1'b0
`define MODE_TEST         1'b1
`endif

// >>> design/mask_shifter.v
// Serial configuration path for the channel mask.
// Assumes s_in and load already synchronised to sys_clk.
`timescale 1ns/1ps
`include "capture_defs.vh"
module mask_shifter #(
    parameter WIDTH = `CHAN_COUNT
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             s_in,
    input  wire             load,
    output reg  [WIDTH-1:0] shadow_q,
    output wire             commit
);
    reg load_q;
    // Commit on the rising edge of the load strobe only
    assign commit = load & ~load_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_q <= {WIDTH{1'b1}};
            load_q   <= 1'b0;
        end else begin
            load_q   <= load;
            shadow_q <= {shadow_q[WIDTH-2:0], s_in};
        end
    end
endmodule // mask_shifter

// >>> design/skid_buffer.v
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and a synchronous consumer.
`timescale 1ns/1ps
module skid_buffer #(
    parameter WIDTH = 128
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:1];
    reg             wr_q;
    reg             rd_q;
    reg [1:0]       cnt_q;
    wire            push;
    wire            pop;
    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    always @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // skid_buffer

// >>> bench/capture_monitor.sv
// Checker for the capture block's bus and stream ports.
// Assumes binding to the top module; one clock domain.
`timescale 1ns/1ps
module capture_monitor #(parameter CHANS = 128) (
    input wire logic             sys_clk,
    input wire logic             rst_b,
    input wire logic [1:0]       cal_mode,
    input wire logic             pipe_valid,
    input wire logic             pipe_ready,
    input wire logic [CHANS-1:0] pipe_data,
    input wire logic             capture_stall,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [3:0]       wb_adr_i,
    input wire logic             wb_ack_o,
    input wire logic             wb_err_o
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire map = wb_adr_i < 4'h2 || (wb_adr_i > 4'h3 && wb_adr_i < 4'h8);
    wire cw = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 4'h0;
    wire stalled = pipe_valid && !pipe_ready;
    AST_ACK_MAPPED: assert property (req && map |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acked");
    AST_ERR_UNMAPPED: assert property (req && !map |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_NO_BOTH: assert property (!(wb_ack_o && wb_err_o))
        else $error("ack and err together");
    AST_CAL_MODE: assert property ($changed(cal_mode) |-> $past(cw) || $past(cw, 2))
        else $error("cal mode moved without ctrl write");
    AST_STREAM_HOLD: assert property (stalled |=> pipe_valid && $stable(pipe_data))
        else $error("pipe word lost while stalled");
    AST_STALL_FULL: assert property (capture_stall |-> pipe_valid)
        else $error("stall with empty buffer");
    AST_STALL_PAST: assert property (capture_stall |-> !$past(pipe_ready))
        else $error("stall although word was taken");
endmodule // capture_monitor
bind strip_input_capture_mask capture_monitor #(.CHANS(CHANS)) i_capture_monitor (
    .sys_clk, .rst_b, .cal_mode, .pipe_valid, .pipe_ready, .pipe_data, .capture_stall,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .wb_err_o);

// >>> bench/front_end_model.sv
// Discriminator chip model driving the hit pins.
// Assumes level changes once per clock, clock-aligned.
`timescale 1ns/1ps
module front_end_model (
    input  wire logic         sys_clk,
    input  wire logic [127:0] level,
    output logic      [127:0] hit
);
    initial hit = 128'h0;
    always @(posedge sys_clk) hit <= level;
endmodule // front_end_model

// >>> bench/tb_top.sv
// Bus-driven bench for the hit capture and mask block.
// Assumes the front-end model and the bound checker.
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 0, rst_b = 0, s_in = 0, load = 0, rdy = 1;
    logic cyc = 0, stb = 0, we = 0, e;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0, r;
    logic [127:0] pat = 128'h0, hit, pd, x;
    logic [1:0] cm;
    logic pv, st, ack, err;
    logic [31:0] dout;
    integer mismatches = 0, total_checks = 0, g, i;
    localparam [127:0] P = {4{32'hA5C3_0F96}};
    initial forever #5 sys_clk = ~sys_clk;
    front_end_model i_front_end_model (.sys_clk(sys_clk), .level(pat), .hit(hit));
    strip_input_capture_mask i_strip_input_capture_mask (.sys_clk(sys_clk),
        .rst_b(rst_b), .hit_in(hit), .cfg_s_in(s_in), .cfg_load(load), .cal_mode(cm),
        .pipe_data(pd), .pipe_valid(pv), .pipe_ready(rdy), .capture_stall(st),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack), .wb_err_o(err));
    task complete_run;
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input string n, input logic [127:0] xp, input logic [127:0] got);
        total_checks++;
        if (got !== xp) begin
            mismatches++;
            $display("mismatch %s exp %h got %h", n, xp, got);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge sys_clk);
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        // Called just after a rising edge; answer is sampled on rising edges only
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1 && err !== 1 && n < 40);
        if (n >= 40) begin
            mismatches++;
            complete_run();
        end
        r = dout;
        e = err;
        cyc <= 0;
        stb <= 0;
        @(posedge sys_clk);
    endtask
    task commit(input logic b);
        s_in <= b; tick(140); load <= 1; tick(6); load <= 0; tick(8);
    endtask
    initial begin
        tick(20); rst_b <= 1; tick(3);
        bus(0, 4'h0, 0); chk("ctrl", 0, r);
        bus(0, 4'h4, 0); chk("mask0", 32'hFFFFFFFF, r);
        bus(0, 4'h2, 0); chk("err", 1, e);
        pat <= P; tick(8); chk("live", P, pd);
        bus(1, 4'h4, 32'h0000FFFF);
        tick(8);
        chk("masked", P & {96'hFFFFFFFF_FFFFFFFF_FFFFFFFF, 32'h0000FFFF}, pd);
        bus(1, 4'h4, 32'hFFFFFFFF);
        pat <= 0;
        for (g = 0; g < 4; g++) begin
            bus(1, 4'h0, 32'h11 | (g << 1));
            tick(8);
            for (i = 0; i < 128; i++) x[i] = (i % 4 == g);
            chk("forced", x, pd);
            chk("calmode", g, cm);
        end
        bus(1, 4'h0, 32'h16); tick(8); chk("testoff", 0, pd);
        bus(1, 4'h5, 32'h12345678);
        bus(1, 4'h0, 32'h08);
        pat <= P;
        tick(8);
        chk("pattern", {64'hFFFFFFFF_FFFFFFFF, 32'h12345678, 32'hFFFFFFFF}, pd);
        bus(1, 4'h0, 0);
        commit(0);
        chk("serial0", 0, pd);
        bus(0, 4'h7, 0); chk("mask3", 0, r);
        commit(1);
        bus(0, 4'h7, 0);
        chk("mask3b", 32'hFFFFFFFF, r);
        // Two commits so far; buffer holds one word and can take another
        bus(0, 4'h1, 0);
        chk("status", 32'h0003_0002, r);
        // Forced level 0 clears every fourth live channel from channel 0
        bus(1, 4'h0, 32'h01);
        tick(8);
        chk("forcelow", P & {32{4'hE}}, pd);
        bus(1, 4'h0, 0);
        tick(8);
        rdy <= 0;
        i = 0;
        while (st !== 1 && i < 20) begin
            tick(1);
            i++;
        end
        if (i >= 20) begin
            mismatches++;
            complete_run();
        end
        chk("stall", 1, st);
        chk("valid", 1, pv);
        chk("held", P, pd);
        rdy <= 1; tick(3); chk("drained", 0, st);
        complete_run();
    end
endmodule // tb_top
